// File: design/mvd_pkg.sv
// Package with constants and carrier types for the move instruction decoder.
package mvd_pkg;
  localparam int INSTR_W = 16;
  localparam int DATA_W = 8;
  localparam int FMT_BIT = 15;
  localparam int SRC_LSB = 0;
  localparam int SRC_W = 8;
  localparam int SRC_MOD_LSB = 0;
  localparam int SRC_IDX_LSB = 4;
  localparam int MOD_W = 4;
  localparam int SRC_IDX_W = 4;
  localparam int DST_MOD_LSB = 8;
  localparam int DST_SUB_LSB = 12;
  localparam int DST_SUB_W = 3;
  localparam int PFX_W = 2;
  localparam int DST_IDX_W = DST_SUB_W + PFX_W;
  localparam int STK_DEPTH = 4;
  localparam int STK_W = 16;
  localparam int SP_W = 2;
  localparam logic [SP_W-1:0] SP_RESET = 2'h3;
  localparam logic [MOD_W-1:0] PFX_MODULE = 4'hb;
  localparam int NUM_DP = 3;
  localparam int DP_W = 8;

  typedef struct packed {
    logic imm_valid;
    logic [DATA_W-1:0] imm_value;
    logic src_reg_valid;
    logic [MOD_W-1:0] src_module;
    logic [SRC_IDX_W-1:0] src_index;
  } mvd_src_type;

  typedef struct packed {
    logic dst_valid;
    logic [MOD_W-1:0] dst_module;
    logic [DST_IDX_W-1:0] dst_index;
  } mvd_dst_type;

  typedef enum logic [1:0] {
    MVD_DP_NONE = 2'b00,
    MVD_DP_INC = 2'b01,
    MVD_DP_DEC = 2'b10
  } mvd_dp_op_type;
endpackage

// File: design/mvd_return_stack.sv
// Four-entry return-address stack with registered read data.
module mvd_return_stack
  import mvd_pkg::*;
#(
  parameter int DEPTH = STK_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic [STK_W-1:0] push_data_in,
  output logic [STK_W-1:0] pop_data_out,
  output logic [SP_W-1:0] stack_pointer_out
);
  logic [STK_W-1:0] mem_q [DEPTH];
  logic [SP_W-1:0] sp_q;
  logic [SP_W-1:0] sp_inc;
  logic [STK_W-1:0] rd_q;

  assign sp_inc = sp_q + 2'h1;
  assign stack_pointer_out = sp_q;
  assign pop_data_out = rd_q;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      sp_q <= SP_RESET;
      rd_q <= 16'h0000;
    end else if (push_in) begin
      sp_q <= sp_inc;
      mem_q[sp_inc] <= push_data_in;
    end else if (pop_in) begin
      rd_q <= mem_q[sp_q];
      sp_q <= sp_q - 2'h1;
    end
  end

  chk_sp_reset_top: assert property (@(posedge ref_clk_in) !rst_b_in |=> sp_q == SP_RESET)
    else $error("Stack pointer not at top after reset.");
  chk_push_inc_store: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    push_in |=> sp_q == $past(sp_q) + 2'h1 && mem_q[sp_q] == $past(push_data_in))
    else $error("Push did not increment then store.");
  chk_pop_read_dec: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    pop_in && !push_in |=> rd_q == $past(mem_q[sp_q]) && sp_q == $past(sp_q) - 2'h1)
    else $error("Pop did not read then decrement.");
endmodule

// File: design/mvd_decoder.sv
// Single-cycle move instruction decoder with prefix, stack and data pointers.
// Behaviour
// - Each instruction is one fixed 16-bit word.
// - Bit 15 selects immediate or register source.
// - Bits 0 to 7 form the source field.
// - Source register: low nibble module, high nibble index.
// - Bits 8 to 14 select destination: low four module, top three subindex.
// - Upper destination indexes need extra bits from the destination prefix.
// - A prefix write is its own instruction costing one cycle.
// - Fetch and execute complete in one cycle without pipeline.
// - Operations are register moves; selects trigger side effects.
// - ALU uses accumulator with any register, 8 bits wide.
// - Hardware return stack is four entries deep.
// - Three data pointers auto increment or decrement, pre or post.
// - Stack pointer resets to 03h.
// - Push increments then stores; pop reads then decrements.
module mvd_decoder
  import mvd_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic instr_valid_in,
  input wire logic [INSTR_W-1:0] instr_in,
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic [STK_W-1:0] push_data_in,
  input wire logic [NUM_DP-1:0] dp_sel_in,
  input wire logic [1:0] dp_op_in,
  input wire logic dp_pre_in,
  input wire logic [DATA_W-1:0] accumulator_in,
  input wire logic [DATA_W-1:0] src_data_in,
  output mvd_src_type src_out,
  output mvd_dst_type dst_out,
  output logic [DATA_W-1:0] alu_a_out,
  output logic [DATA_W-1:0] alu_b_out,
  output logic [PFX_W-1:0] destination_prefix_out,
  output logic [STK_W-1:0] pop_data_out,
  output logic [SP_W-1:0] stack_pointer_out,
  output logic [NUM_DP*DP_W-1:0] dp_addr_out,
  output logic [NUM_DP*DP_W-1:0] dp_value_out
);
  logic fmt_imm;
  logic [SRC_W-1:0] src_field;
  logic [MOD_W-1:0] dst_mod;
  logic [DST_SUB_W-1:0] dst_sub;
  logic pfx_write;
  logic [PFX_W-1:0] pfx_q;
  logic [PFX_W-1:0] pfx_d;
  mvd_src_type src_q;
  mvd_src_type src_d;
  mvd_dst_type dst_q;
  mvd_dst_type dst_d;
  logic [DATA_W-1:0] alu_b_q;
  logic [DATA_W-1:0] alu_a_q;
  logic [DP_W-1:0] dp_q [NUM_DP];

  function automatic logic [DP_W-1:0] dp_step(input logic [DP_W-1:0] v, input logic [1:0] op);
    dp_step = (op == MVD_DP_INC) ? v + 8'h01 : (op == MVD_DP_DEC) ? v - 8'h01 : v;
  endfunction

  assign fmt_imm = ~instr_in[FMT_BIT];
  assign src_field = instr_in[SRC_LSB +: SRC_W];
  assign dst_mod = instr_in[DST_MOD_LSB +: MOD_W];
  assign dst_sub = instr_in[DST_SUB_LSB +: DST_SUB_W];
  assign pfx_write = instr_valid_in && dst_mod == PFX_MODULE;

  assign src_d.imm_valid = instr_valid_in && fmt_imm;
  assign src_d.imm_value = fmt_imm ? src_field : 8'h00;
  assign src_d.src_reg_valid = instr_valid_in && !fmt_imm;
  assign src_d.src_module = fmt_imm ? 4'h0 : src_field[SRC_MOD_LSB +: MOD_W];
  assign src_d.src_index = fmt_imm ? 4'h0 : src_field[SRC_IDX_LSB +: SRC_IDX_W];
  assign dst_d.dst_valid = instr_valid_in;
  assign dst_d.dst_module = dst_mod;
  assign dst_d.dst_index = {pfx_q, dst_sub};
  assign pfx_d = pfx_write ? dst_sub[PFX_W-1:0] : (instr_valid_in ? 2'h0 : pfx_q);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      pfx_q <= 2'h0;
      src_q <= '0;
      dst_q <= '0;
      alu_a_q <= 8'h00;
      alu_b_q <= 8'h00;
    end else begin
      pfx_q <= pfx_d;
      src_q <= src_d;
      dst_q <= dst_d;
      alu_a_q <= accumulator_in;
      alu_b_q <= fmt_imm ? src_field : src_data_in;
    end
  end

  assign src_out = src_q;
  assign dst_out = dst_q;
  assign alu_a_out = alu_a_q;
  assign alu_b_out = alu_b_q;
  assign destination_prefix_out = pfx_q;

  genvar g;
  generate
    for (g = 0; g < NUM_DP; g++) begin : g_dp
      logic [DP_W-1:0] pre_v;
      assign pre_v = dp_pre_in ? dp_step(dp_q[g], dp_op_in) : dp_q[g];
      always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
          dp_q[g] <= 8'h00;
          dp_addr_out[g*DP_W +: DP_W] <= 8'h00;
        end else if (dp_sel_in[g]) begin
          dp_addr_out[g*DP_W +: DP_W] <= pre_v;
          dp_q[g] <= dp_step(dp_q[g], dp_op_in);
        end
      end
      assign dp_value_out[g*DP_W +: DP_W] = dp_q[g];
      chk_dp_unsel_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        !dp_sel_in[g] |=> dp_q[g] == $past(dp_q[g])
          && dp_addr_out[g*DP_W +: DP_W] == $past(dp_addr_out[g*DP_W +: DP_W]))
        else $error("Unselected data pointer moved.");
      chk_dp_pre_step: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        dp_sel_in[g] && dp_pre_in |=> dp_addr_out[g*DP_W +: DP_W] == dp_q[g])
        else $error("Pre-modified address differs from the new pointer.");
      chk_dp_post_step: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        dp_sel_in[g] && !dp_pre_in |=> dp_addr_out[g*DP_W +: DP_W] == $past(dp_q[g]))
        else $error("Post-modified address differs from the old pointer.");
      chk_dp_dec_step: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        dp_sel_in[g] && dp_op_in == 2'b10 |=> dp_q[g] == $past(dp_q[g]) - 8'h01)
        else $error("Pointer decrement wrong.");
      chk_dp_none_step: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        dp_sel_in[g] && dp_op_in[0] == dp_op_in[1] |=> dp_q[g] == $past(dp_q[g]))
        else $error("Pointer moved without a step.");
    end
  endgenerate

  mvd_return_stack #(
    .DEPTH(STK_DEPTH)
  ) u_stack (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .push_in(push_in),
    .pop_in(pop_in),
    .push_data_in(push_data_in),
    .pop_data_out(pop_data_out),
    .stack_pointer_out(stack_pointer_out)
  );

  chk_src_imm_fmt: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    instr_valid_in && !instr_in[15] |=> src_out.imm_valid && src_out.imm_value == $past(instr_in[7:0]))
    else $error("Immediate source not decoded.");
  chk_src_reg_split: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    instr_valid_in && instr_in[15] |=> src_out.src_reg_valid
      && src_out.src_module == $past(instr_in[3:0]) && src_out.src_index == $past(instr_in[7:4]))
    else $error("Register source fields wrong.");
  chk_dst_split: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    instr_valid_in |=> dst_out.dst_module == $past(instr_in[11:8])
      && dst_out.dst_index[2:0] == $past(instr_in[14:12]))
    else $error("Destination fields wrong.");
  chk_pfx_extends_next: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    instr_valid_in && instr_in[11:8] == 4'hb ##1 instr_valid_in
      |=> dst_out.dst_index[4:3] == $past(instr_in[13:12], 2))
    else $error("Prefix did not extend following destination.");
  chk_pfx_one_shot: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    instr_valid_in && instr_in[11:8] != 4'hb |=> pfx_q == 2'h0)
    else $error("Prefix not cleared after use.");
  chk_pfx_one_cycle: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    instr_valid_in && instr_in[11:8] == 4'hb |=> pfx_q == $past(instr_in[13:12]))
    else $error("Prefix write not taken in one cycle.");
  chk_alu_operand_b: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    instr_in[15] |=> alu_b_out == $past(src_data_in) && alu_a_out == $past(accumulator_in))
    else $error("ALU operands wrong.");
  chk_dp_post_inc: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    dp_sel_in[0] && !dp_pre_in && dp_op_in == 2'b01
      |=> dp_addr_out[7:0] == $past(dp_q[0]) && dp_q[0] == $past(dp_q[0]) + 8'h01)
    else $error("Post increment wrong.");

  // Valid flags answer in the next cycle only.
  chk_idle_no_valid: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    !instr_valid_in |=> !src_out.imm_valid && !src_out.src_reg_valid && !dst_out.dst_valid)
    else $error("Valid flag raised without an instruction.");
  chk_answer_next_cycle: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    instr_valid_in |=> dst_out.dst_valid && (src_out.imm_valid != src_out.src_reg_valid))
    else $error("Instruction not answered in the next cycle.");
  chk_reset_clears_out: assert property (@(posedge ref_clk_in)
    !rst_b_in |=> destination_prefix_out == 2'h0 && !dst_out.dst_valid
      && !src_out.imm_valid && !src_out.src_reg_valid)
    else $error("Decoder outputs not cleared by reset.");

  // Unused source fields stay at zero.
  chk_src_reg_no_imm: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    instr_valid_in && instr_in[15] |=> !src_out.imm_valid && src_out.imm_value == 8'h00)
    else $error("Register source leaked an immediate.");
  chk_src_imm_no_reg: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    instr_valid_in && !instr_in[15] |=> !src_out.src_reg_valid
      && src_out.src_module == 4'h0 && src_out.src_index == 4'h0)
    else $error("Immediate source leaked register selects.");

  // The prefix lives until the next instruction.
  chk_pfx_idle_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    !instr_valid_in |=> pfx_q == $past(pfx_q))
    else $error("Prefix changed during an idle cycle.");
  chk_dst_no_pfx: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    instr_valid_in && instr_in[11:8] != 4'hb ##1 instr_valid_in
      |=> dst_out.dst_index[4:3] == 2'h0)
    else $error("Unprefixed destination got upper index bits.");

  // Operand registers and stack outputs.
  chk_alu_imm_operand: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    !instr_in[15] |=> alu_b_out == $past(instr_in[7:0]))
    else $error("Immediate operand not passed to the ALU.");
  chk_alu_a_every: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    1'b1 |=> alu_a_out == $past(accumulator_in))
    else $error("Accumulator operand not registered.");
  chk_stack_idle_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    !push_in && !pop_in |=> stack_pointer_out == $past(stack_pointer_out)
      && pop_data_out == $past(pop_data_out))
    else $error("Stack outputs moved without an operation.");
  chk_stack_push_sp: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    push_in |=> stack_pointer_out == $past(stack_pointer_out) + 2'h1)
    else $error("Push did not advance the stack pointer.");
  chk_stack_pop_sp: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    pop_in && !push_in |=> stack_pointer_out == $past(stack_pointer_out) - 2'h1)
    else $error("Pop did not retreat the stack pointer.");
endmodule

// File: sim/mvd_prog_mem.sv
// Program memory model that hands the decoder one instruction word per address.
module mvd_prog_mem
  import mvd_pkg::*;
(
  input wire logic [2:0] addr_in,
  output logic [INSTR_W-1:0] instr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [INSTR_W-1:0] rom [8];
  assign instr_out = rom[addr_in];
  initial begin
    rom = '{16'h0a5c, 16'h3b30, 16'h8134, 16'h8134, 16'h7f91, 16'h0, 16'h0, 16'h0};
  end
endmodule

// File: sim/test_mvd_decoder.sv
// Self-checking testbench for the move instruction decoder.
module test_mvd_decoder
  import mvd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, iv = 1'b0, push = 1'b0, pop = 1'b0, pre = 1'b0;
  logic [2:0] pc = 3'h0, sel = 3'h0;
  logic [1:0] op = 2'h0;
  logic [7:0] acc = 8'h00, sd = 8'h00;
  logic [15:0] pd = 16'h0000, instr, popd;
  mvd_src_type src;
  mvd_dst_type dst;
  logic [7:0] a, b;
  logic [1:0] destination_prefix, sp;
  logic [23:0] dpa, dpv;
  int error_cnt = 0, check_count = 0;
  mvd_prog_mem mem_u (.addr_in(pc), .instr_out(instr));
  mvd_decoder dut_u (.ref_clk_in(clk), .rst_b_in(rst_b), .instr_valid_in(iv), .instr_in(instr),
    .push_in(push), .pop_in(pop), .push_data_in(pd), .dp_sel_in(sel), .dp_op_in(op),
    .dp_pre_in(pre), .accumulator_in(acc), .src_data_in(sd), .src_out(src), .dst_out(dst),
    .alu_a_out(a), .alu_b_out(b), .destination_prefix_out(destination_prefix), .pop_data_out(popd),
    .stack_pointer_out(sp), .dp_addr_out(dpa), .dp_value_out(dpv));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic cmp(input logic [23:0] g, input logic [23:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic step(input logic [2:0] p, input logic v);
    pc = p;
    iv = v;
    @(negedge clk);
  endtask
  task automatic so(input logic p, input logic o, input logic [15:0] d);
    push = p;
    pop = o;
    pd = d;
    @(negedge clk);
  endtask
  task automatic dp(input logic [2:0] s, input logic [1:0] o, input logic p);
    sel = s;
    op = o;
    pre = p;
    @(negedge clk);
  endtask
  task automatic t_reset();
    cmp(sp, 24'h3);
    cmp(src, 24'h0);
    cmp({dst, destination_prefix}, 24'h0);
    cmp({a, b}, 24'h0);
    cmp(popd, 24'h0);
    cmp(dpa, 24'h0);
    cmp(dpv, 24'h0);
    $display("Reset test done");
  endtask
  task automatic t_imm();
    acc = 8'h3c;
    step(3'h0, 1'b1);
    cmp({src.imm_valid, src.imm_value, src.src_reg_valid}, 24'h2b8);
    cmp(dst, 24'h340);
    cmp({a, b}, 24'h3c5c);
    step(3'h4, 1'b1);
    cmp(src.imm_value, 24'h91);
    cmp(dst, 24'h3e7);
    $display("Immediate test done");
  endtask
  task automatic t_pfx();
    sd = 8'h6e;
    step(3'h1, 1'b1);
    cmp(destination_prefix, 24'h3);
    step(3'h1, 1'b0);
    cmp({destination_prefix, dst.dst_valid}, 24'h6);
    step(3'h2, 1'b1);
    cmp({src.imm_valid, src.src_reg_valid, src.src_module, src.src_index}, 24'h143);
    cmp(dst, 24'h238);
    cmp({b, destination_prefix}, 24'h1b8);
    step(3'h3, 1'b1);
    cmp(dst, 24'h220);
    step(3'h1, 1'b1);
    cmp(destination_prefix, 24'h3);
    step(3'h2, 1'b1);
    cmp({dst, destination_prefix}, 24'h8e0);
    step(3'h0, 1'b0);
    $display("Prefix test done");
  endtask
  task automatic t_stack();
    so(1'b1, 1'b0, 16'h1234);
    cmp(sp, 24'h0);
    so(1'b1, 1'b0, 16'h5678);
    cmp(sp, 24'h1);
    so(1'b0, 1'b1, 16'h0);
    cmp({popd, sp}, 24'h159e0);
    so(1'b0, 1'b1, 16'h0);
    cmp({popd, sp}, 24'h48d3);
    so(1'b0, 1'b0, 16'h0);
    $display("Stack test done");
  endtask
  task automatic t_dp();
    dp(3'h1, 2'h1, 1'b0);
    cmp({dpa[7:0], dpv[7:0]}, 24'h0001);
    dp(3'h1, 2'h2, 1'b1);
    cmp({dpa[7:0], dpv[7:0]}, 24'h0000);
    dp(3'h7, 2'h1, 1'b1);
    cmp(dpa, 24'h010101);
    cmp(dpv, 24'h010101);
    dp(3'h2, 2'h3, 1'b1);
    cmp({dpa[15:8], dpv[15:8]}, 24'h0101);
    dp(3'h0, 2'h0, 1'b0);
    $display("Data pointer test done");
  endtask
  initial begin
    #3000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    repeat (16) @(negedge clk);
    t_reset();
    rst_b = 1'b1;
    @(negedge clk);
    t_imm();
    t_pfx();
    t_stack();
    t_dp();
    tally_and_finish();
  end
endmodule
